// ---- logic/paging_prot_pkg.sv ----
// constants and types shared by the paging protection logic
package paging_prot_pkg;
    // page table entry layout
    localparam int PTE_W = 16;
    localparam int PTE_RING_LO = 9;
    localparam int PTE_RING_HI = 10;
    localparam int PTE_DIRTY_BIT = 11;
    localparam int PTE_REF_BIT = 12;
    localparam int PTE_EXEC_BIT = 13;
    localparam int PTE_READ_BIT = 14;
    localparam int PTE_WRITE_BIT = 15;
    // fault status layout
    localparam int FS_FETCH_BIT = 15;
    localparam int FS_PERMIT_BIT = 14;
    localparam int FS_TABLE_LO = 6;
    localparam int FS_TABLE_HI = 7;
    localparam int FS_PAGE_LO = 0;
    localparam int FS_PAGE_HI = 5;
    localparam logic [15:0] FAULT_STATUS_RESET = 16'h0000;
    // level map control layout: ring 1:0, table 3:2, alternate table 5:4
    localparam int LMC_W = 6;
    localparam int LMC_RING_LO = 0;
    localparam int LMC_TABLE_LO = 2;
    localparam int LMC_ALT_LO = 4;
    localparam logic [5:0] LMC_RESET = 6'h00;
    localparam int NUM_LEVELS = 16;
    // interrupt routing
    localparam logic [3:0] FAULT_LEVEL = 4'hE;
    localparam logic [3:0] CAUSE_PROTECT_VIOLATION = 4'h2;
    localparam logic [3:0] CAUSE_PAGE_ABSENT = 4'h3;
    localparam logic [3:0] CAUSE_PRIVILEGED = 4'h4;
    localparam logic [3:0] CAUSE_SUPERVISOR_CALL = 4'h5;
    localparam logic [1:0] PRIV_MIN_RING = 2'h2;
    localparam logic [1:0] RING_W_FULL = 2'h3;
    typedef enum logic [1:0] {ACC_FETCH, ACC_READ, ACC_WRITE, ACC_INDIRECT} access_kind_t;
endpackage

// ---- logic/ring_permit_check.sv ----
// combinational ring and permit check of one reference against one entry
`timescale 1ns/100ps
module ring_permit_check
    import paging_prot_pkg::*;
(
    input wire logic [15:0] entry,
    input wire logic [1:0] run_ring,
    input wire paging_prot_pkg::access_kind_t kind,
    output logic absent,
    output logic ring_bad,
    output logic permit_bad
);
    logic wr_ok;
    logic rd_ok;
    logic ex_ok;
    logic [1:0] page_ring;

    assign wr_ok = entry[PTE_WRITE_BIT];
    assign rd_ok = entry[PTE_READ_BIT];
    assign ex_ok = entry[PTE_EXEC_BIT];
    assign page_ring = entry[PTE_RING_HI:PTE_RING_LO];
    // page ring must not exceed running ring
    assign ring_bad = page_ring > run_ring;
    assign absent = !wr_ok && !rd_ok && !ex_ok;

    always_comb begin
        case (kind)
            ACC_WRITE: permit_bad = !wr_ok;
            ACC_READ: permit_bad = !rd_ok;
            ACC_FETCH: permit_bad = !ex_ok;
            ACC_INDIRECT: permit_bad = !(ex_ok || rd_ok);
            default: permit_bad = 1'b1;
        endcase
    end
endmodule

// ---- logic/ring_permit_paging_protection.sv ----
// paging protection, reference status and fault status capture
`timescale 1ns/100ps
// Functional notes
// - entry ring lives in bits 10 and 9
// - ring 0 reaches only ring 0 pages
// - ring 1 reaches rings 1 and 0
// - ring 2 reaches rings 2, 1, 0
// - ring 3 reaches everything, permits permitting
// - ring breach: privileged interrupt, level 14, suppressed
// - compare level ring with entry ring
// - privileged instructions only on rings 2, 3; the code allows them on any ring while mapping is off
// - supervisor call always raises internal interrupt
// - entry bits 11 dirty, 12 referenced
// - hardware sets referenced and dirty flags
// - all permits zero means page absent
// - each fault carries its cause code
// - fault locks status until read op
// - status bit 15 marks fetch fault
// - bit 14 permit versus ring, permit wins
// - bits 7-6 table, 5-0 page
// - fetch fault holds program counter
// - enable op maps from next fetch
// - disable op drops mapping and protection
// - map register written one per op
// - permit violation gives cause code 2
// - write, read, fetch permits bits 15-13
module ring_permit_paging_protection
    import paging_prot_pkg::*;
#(
    parameter int LEVELS = paging_prot_pkg::NUM_LEVELS
)
(
    input wire logic mclk,
    input wire logic resetn,
    // memory reference from the address path
    input wire logic ref_valid,
    input wire paging_prot_pkg::access_kind_t ref_kind,
    input wire logic [3:0] cur_level,
    input wire logic [5:0] ref_page,
    input wire logic use_alt_table,
    input wire logic [15:0] entry_in,
    output logic ref_allow,
    output logic entry_wr,
    output logic [1:0] entry_table,
    output logic [5:0] entry_page,
    output logic [15:0] entry_out,
    // instruction events from the sequencer
    input wire logic instr_privileged,
    input wire logic instr_start,
    input wire logic supervisor_call,
    input wire logic translation_enable_op,
    input wire logic translation_disable_op,
    input wire logic write_level_map_op,
    input wire logic [3:0] map_level_sel,
    input wire logic [5:0] map_wdata,
    input wire logic read_fault_status_op,
    output logic instr_suppress,
    output logic pc_hold,
    output logic fault_irq,
    output logic [3:0] fault_irq_level,
    output logic [3:0] internal_cause_code,
    output logic translation_on,
    output logic [15:0] fault_status_reg,
    output logic fault_locked
);
    import paging_prot_pkg::*;

    // ------------------------------------------------------------
    // level map control registers
    // ------------------------------------------------------------
    logic [LMC_W-1:0] level_map_control_ff [LEVELS];
    logic [LMC_W-1:0] cur_map;
    logic [1:0] run_ring;
    logic [1:0] translation_table;
    logic [1:0] alternate_table_select;
    logic translation_on_ff;
    logic priv_block;

    assign cur_map = level_map_control_ff[cur_level];
    assign run_ring = cur_map[LMC_RING_LO +: 2];
    assign translation_table = cur_map[LMC_TABLE_LO +: 2];
    assign alternate_table_select = cur_map[LMC_ALT_LO +: 2];

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < LEVELS; i++) begin
                level_map_control_ff[i] <= LMC_RESET;
            end
        end else if (write_level_map_op && !priv_block) begin
            // one register per op
            level_map_control_ff[map_level_sel] <= map_wdata;
        end
    end

    // ------------------------------------------------------------
    // translation on/off
    // ------------------------------------------------------------
    // privileged ops need ring 2 or 3 while mapping is on
    assign priv_block = translation_on_ff && run_ring < PRIV_MIN_RING
        && (instr_privileged || translation_enable_op || translation_disable_op
        || write_level_map_op || read_fault_status_op);

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            translation_on_ff <= 1'b0;
        end else if (translation_disable_op && !priv_block) begin
            translation_on_ff <= 1'b0;
        end else if (translation_enable_op && !priv_block) begin
            translation_on_ff <= 1'b1;
        end
    end
    assign translation_on = translation_on_ff;

    // ------------------------------------------------------------
    // reference check
    // ------------------------------------------------------------
    logic absent;
    logic ring_bad;
    logic permit_bad;
    logic chk_on;
    logic fault_absent;
    logic fault_permit;
    logic fault_ring;
    logic ref_fault;

    ring_permit_check u_check (
        .entry(entry_in),
        .run_ring(run_ring),
        .kind(ref_kind),
        .absent(absent),
        .ring_bad(ring_bad),
        .permit_bad(permit_bad)
    );

    // protection only applies while mapping is on
    assign chk_on = ref_valid && translation_on_ff;
    assign fault_absent = chk_on && absent;
    assign fault_permit = chk_on && !absent && permit_bad;
    assign fault_ring = chk_on && !absent && !permit_bad && ring_bad;
    assign ref_fault = fault_absent || fault_permit || fault_ring;
    assign ref_allow = ref_valid && !ref_fault;
    assign instr_suppress = ref_fault || priv_block;
    // fetch fault leaves the program counter alone
    assign pc_hold = ref_fault && ref_kind == ACC_FETCH;

    // ------------------------------------------------------------
    // referenced / dirty write-back
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            entry_wr <= 1'b0;
            entry_table <= 2'h0;
            entry_page <= 6'h00;
            entry_out <= 16'h0000;
        end else begin
            entry_wr <= chk_on && !ref_fault;
            entry_table <= use_alt_table ? alternate_table_select : translation_table;
            entry_page <= ref_page;
            entry_out <= entry_in;
            entry_out[PTE_REF_BIT] <= 1'b1;
            if (ref_kind == ACC_WRITE) begin
                entry_out[PTE_DIRTY_BIT] <= 1'b1;
            end else begin
                entry_out[PTE_DIRTY_BIT] <= entry_in[PTE_DIRTY_BIT];
            end
        end
    end

    // ------------------------------------------------------------
    // internal interrupt request
    // ------------------------------------------------------------
    logic [3:0] nxt_cause;
    logic irq_ff;
    logic [3:0] cause_ff;

    always_comb begin
        if (fault_absent) begin
            nxt_cause = CAUSE_PAGE_ABSENT;
        end else if (fault_permit) begin
            nxt_cause = CAUSE_PROTECT_VIOLATION;
        end else if (fault_ring || priv_block) begin
            nxt_cause = CAUSE_PRIVILEGED;
        end else begin
            nxt_cause = CAUSE_SUPERVISOR_CALL;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            irq_ff <= 1'b0;
            cause_ff <= 4'h0;
        end else begin
            // supervisor call raises on any ring
            irq_ff <= ref_fault || priv_block || supervisor_call;
            cause_ff <= nxt_cause;
        end
    end
    assign fault_irq = irq_ff;
    assign fault_irq_level = FAULT_LEVEL;
    assign internal_cause_code = cause_ff;

    // ------------------------------------------------------------
    // fault status register with lock
    // ------------------------------------------------------------
    logic [15:0] fault_status_ff;
    logic locked_ff;
    logic [1:0] fault_table;
    logic status_read;

    assign fault_table = use_alt_table ? alternate_table_select : translation_table;
    assign status_read = read_fault_status_op && !priv_block;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            fault_status_ff <= FAULT_STATUS_RESET;
        end else if (ref_fault && !locked_ff) begin
            // captured only while unlocked
            fault_status_ff <= FAULT_STATUS_RESET;
            fault_status_ff[FS_FETCH_BIT] <= ref_kind == ACC_FETCH;
            fault_status_ff[FS_PERMIT_BIT] <= fault_permit;
            fault_status_ff[FS_TABLE_HI:FS_TABLE_LO] <= fault_table;
            fault_status_ff[FS_PAGE_HI:FS_PAGE_LO] <= ref_page;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            locked_ff <= 1'b0;
        end else if (ref_fault) begin
            // new fault wins over a same-cycle read
            locked_ff <= 1'b1;
        end else if (status_read) begin
            locked_ff <= 1'b0;
        end
    end
    assign fault_status_reg = fault_status_ff;
    assign fault_locked = locked_ff;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic [1:0] entry_ring;
    assign entry_ring = entry_in[PTE_RING_HI:PTE_RING_LO];

    a_ring_block: assert property (@(posedge mclk) disable iff (!resetn)
        ref_valid && translation_on && !absent && !permit_bad && ring_bad |-> !ref_allow && instr_suppress)
        else $error("ring breach not blocked");
    a_ring_level: assert property (@(posedge mclk) disable iff (!resetn)
        fault_ring |=> fault_irq && internal_cause_code == 4'h4 && fault_irq_level == 4'hE)
        else $error("ring breach cause wrong");
    a_permit_code: assert property (@(posedge mclk) disable iff (!resetn)
        fault_permit |=> fault_irq && internal_cause_code == 4'h2)
        else $error("permit violation cause wrong");
    a_absent_code: assert property (@(posedge mclk) disable iff (!resetn)
        ref_valid && translation_on && entry_in[15:13] == 3'b000 |=> fault_irq && internal_cause_code == 4'h3)
        else $error("absent page not reported");
    a_priv_block: assert property (@(posedge mclk) disable iff (!resetn)
        translation_on && instr_privileged && run_ring < 2'h2 |-> instr_suppress ##1 fault_irq)
        else $error("privileged op on low ring");
    a_svc_irq: assert property (@(posedge mclk) disable iff (!resetn)
        supervisor_call |=> fault_irq)
        else $error("supervisor call silent");
    a_lock_hold: assert property (@(posedge mclk) disable iff (!resetn)
        fault_locked && !(read_fault_status_op && !priv_block) |=> fault_locked && $stable(fault_status_reg))
        else $error("locked status changed");
    a_fetch_bit: assert property (@(posedge mclk) disable iff (!resetn)
        !fault_locked && ref_fault && ref_kind == ACC_FETCH |=> fault_status_reg[15] && fault_locked)
        else $error("fetch bit not captured");
    a_dirty_set: assert property (@(posedge mclk) disable iff (!resetn)
        ref_allow && translation_on && ref_kind == ACC_WRITE |=> entry_wr && entry_out[11] && entry_out[12])
        else $error("dirty flag not set");
    a_off_free: assert property (@(posedge mclk) disable iff (!resetn)
        !translation_on |-> !ref_fault && !priv_block)
        else $error("protection while unmapped");
    a_ring_page: assert property (@(posedge mclk) disable iff (!resetn)
        chk_on && entry_ring > run_ring |-> !ref_allow)
        else $error("higher ring page reached");
    a_ring_zero: assert property (@(posedge mclk) disable iff (!resetn)
        chk_on && run_ring == 2'h0 && entry_ring != 2'h0 |-> !ref_allow)
        else $error("ring 0 left its ring");
    a_ring_one: assert property (@(posedge mclk) disable iff (!resetn)
        chk_on && run_ring == 2'h1 && entry_ring > 2'h1 |-> !ref_allow)
        else $error("ring 1 reached above");
    a_ring_two: assert property (@(posedge mclk) disable iff (!resetn)
        chk_on && run_ring == 2'h2 && entry_ring == 2'h3 |-> !ref_allow)
        else $error("ring 2 reached ring 3");
    a_ring_full: assert property (@(posedge mclk) disable iff (!resetn)
        chk_on && run_ring == RING_W_FULL && ref_kind == ACC_READ && entry_in[PTE_READ_BIT] |-> ref_allow)
        else $error("ring 3 read refused");
    a_ring_ok: assert property (@(posedge mclk) disable iff (!resetn)
        chk_on && ref_kind == ACC_READ && entry_in[PTE_READ_BIT] && entry_ring <= run_ring |-> ref_allow)
        else $error("legal ring read refused");
    a_ring_suppress: assert property (@(posedge mclk) disable iff (!resetn)
        fault_ring |-> instr_suppress ##1 fault_irq_level == 4'hE)
        else $error("ring breach not suppressed");
    a_priv_code: assert property (@(posedge mclk) disable iff (!resetn)
        translation_on && instr_privileged && run_ring < PRIV_MIN_RING && !ref_valid |=> internal_cause_code == 4'h4)
        else $error("privileged op cause wrong");
    a_priv_free: assert property (@(posedge mclk) disable iff (!resetn)
        translation_on && instr_privileged && run_ring >= PRIV_MIN_RING && !ref_valid |-> !instr_suppress)
        else $error("privileged op blocked on high ring");
    a_svc_code: assert property (@(posedge mclk) disable iff (!resetn)
        supervisor_call && !ref_valid && !priv_block |=> internal_cause_code == 4'h5)
        else $error("supervisor call cause wrong");
    a_ref_flag: assert property (@(posedge mclk) disable iff (!resetn)
        entry_wr |-> entry_out[PTE_REF_BIT])
        else $error("referenced flag not set");
    a_dirty_keep: assert property (@(posedge mclk) disable iff (!resetn)
        chk_on && !ref_fault && ref_kind != ACC_WRITE |=> entry_out[PTE_DIRTY_BIT] == $past(entry_in[PTE_DIRTY_BIT]))
        else $error("dirty flag changed on read");
    a_absent_stop: assert property (@(posedge mclk) disable iff (!resetn)
        chk_on && entry_in[15:13] == 3'b000 |-> !ref_allow && instr_suppress)
        else $error("absent page reached");
    a_lock_set: assert property (@(posedge mclk) disable iff (!resetn)
        ref_fault |=> fault_locked && fault_irq)
        else $error("fault did not lock");
    a_lock_clear: assert property (@(posedge mclk) disable iff (!resetn)
        fault_locked && status_read && !ref_fault |=> !fault_locked)
        else $error("status read did not unlock");
    a_data_bit: assert property (@(posedge mclk) disable iff (!resetn)
        !fault_locked && ref_fault && ref_kind != ACC_FETCH |=> !fault_status_reg[15])
        else $error("data fault marked as fetch");
    a_permit_wins: assert property (@(posedge mclk) disable iff (!resetn)
        !fault_locked && fault_permit && ring_bad |=> fault_status_reg[14] && internal_cause_code == 4'h2)
        else $error("permit fault lost to ring");
    a_ring_bit: assert property (@(posedge mclk) disable iff (!resetn)
        !fault_locked && fault_ring |=> !fault_status_reg[14])
        else $error("ring fault marked as permit");
    a_page_capture: assert property (@(posedge mclk) disable iff (!resetn)
        !fault_locked && ref_fault |=> fault_status_reg[5:0] == $past(ref_page))
        else $error("fault page not captured");
    a_table_capture: assert property (@(posedge mclk) disable iff (!resetn)
        !fault_locked && ref_fault && !use_alt_table |=> fault_status_reg[7:6] == $past(translation_table))
        else $error("fault table not captured");
    a_pc_fetch: assert property (@(posedge mclk) disable iff (!resetn)
        chk_on && ref_kind == ACC_FETCH && !entry_in[PTE_EXEC_BIT] |-> pc_hold && instr_suppress)
        else $error("fetch fault moved counter");
    a_enable_next: assert property (@(posedge mclk) disable iff (!resetn)
        translation_enable_op && !translation_disable_op && !priv_block |=> translation_on)
        else $error("enable op ignored");
    a_disable_now: assert property (@(posedge mclk) disable iff (!resetn)
        translation_disable_op && !priv_block |=> !translation_on)
        else $error("disable op ignored");
    a_map_write: assert property (@(posedge mclk) disable iff (!resetn)
        write_level_map_op && !priv_block |=> level_map_control_ff[$past(map_level_sel)] == $past(map_wdata))
        else $error("map register not written");
    a_permit_write: assert property (@(posedge mclk) disable iff (!resetn)
        chk_on && ref_kind == ACC_WRITE && !entry_in[PTE_WRITE_BIT] |-> !ref_allow && instr_suppress)
        else $error("denied write let through");
endmodule

// ---- tb/addr_path_model.sv ----
// page table store standing in for the address path
`timescale 1ns/100ps
module addr_path_model (
    input wire logic mclk,
    input wire logic [5:0] ref_page,
    input wire logic entry_wr,
    input wire logic [5:0] entry_page,
    input wire logic [15:0] entry_out,
    output logic [15:0] entry_in
);
    logic [15:0] mem [64];
    initial foreach (mem[i]) mem[i] = 16'h0000;
    // entry looked up in the same cycle as the reference
    assign entry_in = mem[ref_page];
    // flags reach the table only by write-back, never cleared here
    always @(posedge mclk) begin
        if (entry_wr) begin
            mem[entry_page] <= entry_out;
        end
    end
    task automatic set_entry(input logic [5:0] p, input logic [15:0] v);
        mem[p] = v;
    endtask
endmodule

// ---- tb/test_ring_permit_paging_protection.sv ----
// self-checking bench for the paging protection block
`timescale 1ns/100ps
module test_ring_permit_paging_protection;
    import paging_prot_pkg::*;
    localparam logic [5:0] PRV = 6'h20, SVC = 6'h10, ENA = 6'h08, DIS = 6'h04, MAP = 6'h02, RDS = 6'h01;
    logic mclk, resetn, ref_valid, use_alt_table, instr_start, entry_wr, ref_allow;
    logic instr_suppress, pc_hold, fault_irq, translation_on, fault_locked, allow_s, supp_s, hold_s;
    logic instr_privileged, supervisor_call, translation_enable_op, translation_disable_op;
    logic write_level_map_op, read_fault_status_op;
    access_kind_t ref_kind;
    logic [1:0] entry_table;
    logic [3:0] cur_level, map_level_sel, fault_irq_level, internal_cause_code;
    logic [5:0] ref_page, map_wdata, ev, entry_page;
    logic [15:0] entry_in, entry_out, fault_status_reg;
    int fail_count, checks, cycles;
    assign {instr_privileged, supervisor_call, translation_enable_op, translation_disable_op,
        write_level_map_op, read_fault_status_op} = ev;
    ring_permit_paging_protection ring_permit_paging_protection_inst (.mclk, .resetn, .ref_valid,
        .ref_kind, .cur_level, .ref_page, .use_alt_table, .entry_in, .ref_allow, .entry_wr, .entry_table,
        .entry_page, .entry_out, .instr_privileged, .instr_start, .supervisor_call, .translation_enable_op,
        .translation_disable_op, .write_level_map_op, .map_level_sel, .map_wdata, .read_fault_status_op,
        .instr_suppress, .pc_hold, .fault_irq, .fault_irq_level, .internal_cause_code, .translation_on,
        .fault_status_reg, .fault_locked);
    addr_path_model addr_path_model_inst (.mclk, .ref_page, .entry_wr, .entry_page, .entry_out, .entry_in);
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            end_sim;
        end
    end
    task automatic end_sim;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    function automatic logic [15:0] ent(input logic [2:0] wrx, input logic [1:0] rg);
        return {wrx, 2'b00, rg, 9'h033};
    endfunction
    task automatic se(input logic [5:0] p, input logic [15:0] v);
        addr_path_model_inst.set_entry(p, v);
    endtask
    // one reference, returns where registered answers stand
    task automatic mref(input access_kind_t k, input logic [3:0] l, input logic [5:0] p, input logic a);
        @(negedge mclk);
        ref_valid = 1'b1;
        ref_kind = k;
        cur_level = l;
        ref_page = p;
        use_alt_table = a;
        #1;
        allow_s = ref_allow;
        supp_s = instr_suppress;
        hold_s = pc_hold;
        @(negedge mclk);
        ref_valid = 1'b0;
    endtask
    task automatic op(input logic [5:0] e, input logic [3:0] l);
        @(negedge mclk);
        ev = e;
        cur_level = l;
        #1;
        supp_s = instr_suppress;
        @(negedge mclk);
        ev = 6'h00;
    endtask
    task automatic fchk(input logic [3:0] c, input logic [15:0] st);
        chk("irq", 1, fault_irq);
        chk("cause", c, internal_cause_code);
        chk("level", FAULT_LEVEL, fault_irq_level);
        chk("status", st, fault_status_reg & 16'hC0FF);
    endtask
    task automatic clr;
        op(RDS, 4'h3);
        chk("locked", 0, fault_locked);
    endtask
    initial begin
        resetn = 0; ref_valid = 0; ref_kind = ACC_FETCH; cur_level = 0; ref_page = 0;
        use_alt_table = 0; instr_start = 0; ev = 0; map_level_sel = 0; map_wdata = 0;
        fail_count = 0; checks = 0; cycles = 0;
        repeat (4) @(posedge mclk);
        @(negedge mclk) resetn = 1'b1;
        chk("status", FAULT_STATUS_RESET, fault_status_reg);
        chk("xlate", 0, translation_on);
        se(6'h05, ent(3'b000, 2'h3));
        mref(ACC_WRITE, 4'h0, 6'h05, 1'b0);
        chk("allow", 1, allow_s);
        op(PRV, 4'h0);
        chk("suppress", 0, supp_s);
        for (int l = 0; l < 4; l++) begin
            map_level_sel = 4'(l);
            map_wdata = {2'h1, 2'h2, 2'(l)};
            op(MAP, 4'h0);
        end
        op(ENA, 4'h3);
        chk("xlate", 1, translation_on);
        $display("test reset and setup done");
        for (int r = 0; r < 4; r++) for (int e = 0; e < 4; e++) begin
            se(6'(e), ent(3'b110, 2'(e)));
            mref(ACC_READ, 4'(r), 6'(e), 1'b0);
            chk("ring allow", e <= r, allow_s);
            if (e > r) begin
                fchk(CAUSE_PRIVILEGED, {8'h00, 2'h2, 6'(e)});
                chk("suppress", 1, supp_s);
                clr;
            end
        end
        chk("ref flag", 16'h1000, addr_path_model_inst.mem[0] & 16'h1800);
        mref(ACC_WRITE, 4'h3, 6'h01, 1'b0);
        chk("write back", 1, entry_wr);
        chk("flags", 16'h1800, entry_out & 16'h1800);
        chk("page", 16'h0001, {10'h000, entry_page});
        chk("table", 16'h0002, {14'h0000, entry_table});
        $display("test rings done");
        se(6'h08, ent(3'b010, 2'h3));
        mref(ACC_WRITE, 4'h3, 6'h08, 1'b1);
        chk("hold", 0, hold_s);
        fchk(CAUSE_PROTECT_VIOLATION, 16'h4048);
        clr;
        mref(ACC_WRITE, 4'h0, 6'h08, 1'b0);
        fchk(CAUSE_PROTECT_VIOLATION, 16'h4088);
        chk("locked", 1, fault_locked);
        mref(ACC_FETCH, 4'h3, 6'h08, 1'b0);
        chk("hold", 1, hold_s);
        fchk(CAUSE_PROTECT_VIOLATION, 16'h4088);
        clr;
        mref(ACC_FETCH, 4'h3, 6'h08, 1'b0);
        fchk(CAUSE_PROTECT_VIOLATION, 16'hC088);
        clr;
        mref(ACC_INDIRECT, 4'h3, 6'h08, 1'b0);
        chk("allow", 1, allow_s);
        se(6'h09, 16'h0000);
        mref(ACC_READ, 4'h3, 6'h09, 1'b0);
        chk("cause", CAUSE_PAGE_ABSENT, internal_cause_code);
        op(RDS, 4'h1);
        chk("locked", 1, fault_locked);
        clr;
        $display("test permits done");
        op(PRV, 4'h1);
        chk("suppress", 1, supp_s);
        chk("cause", CAUSE_PRIVILEGED, internal_cause_code);
        op(PRV, 4'h2);
        chk("suppress", 0, supp_s);
        map_level_sel = 4'h3;
        map_wdata = 6'h00;
        op(MAP, 4'h0);
        chk("suppress", 1, supp_s);
        op(PRV, 4'h3);
        chk("suppress", 0, supp_s);
        op(SVC, 4'h0);
        chk("irq", 1, fault_irq);
        chk("cause", CAUSE_SUPERVISOR_CALL, internal_cause_code);
        op(DIS, 4'h3);
        chk("xlate", 0, translation_on);
        mref(ACC_WRITE, 4'h0, 6'h08, 1'b0);
        chk("allow", 1, allow_s);
        $display("test privileged done");
        end_sim;
    end
endmodule
